/* File: dv/sdci_array_model.sv */
// array model answering the block's write and read requests
`timescale 1ns/1ns
`default_nettype none
module sdci_array_model (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_lane_en,
  input wire logic [1:0] wr_bank,
  input wire logic [9:0] wr_col,
  input wire logic rd_req,
  input wire logic [1:0] rd_bank,
  input wire logic [9:0] rd_col,
  output logic [15:0] rd_word
);
  // row ignored to keep the store small
  logic [15:0] mem [0:4095] = '{default: 16'h0000};
  assign wr_ready = !stall;
  always @(posedge sys_clk) begin
    if (wr_valid && wr_ready && wr_lane_en[0]) mem[{wr_bank, wr_col}][7:0] <= wr_data[7:0];
    if (wr_valid && wr_ready && wr_lane_en[1]) mem[{wr_bank, wr_col}][15:8] <= wr_data[15:8];
  end
  // no request: inverted word so a stale value never passes
  assign rd_word = rd_req ? mem[{rd_bank, rd_col}] : ~mem[{rd_bank, rd_col}];
endmodule
`default_nettype wire

/* File: dv/sdci_core_bench.sv */
// testbench for the sdram command interface
`timescale 1ns/1ns
`default_nettype none
module sdci_core_bench;
  import sdci_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, link_clk = 1'b0, clock_gate = 1'b1, stall = 1'b0;
  logic chip_select_n = 1'b0, row_strobe_n = 1'b1, column_strobe_n = 1'b1;
  logic write_strobe_n = 1'b1, low_byte_mask = 1'b0, high_byte_mask = 1'b0;
  logic interleave_cfg = 1'b0, burst_running, wr_valid, wr_ready, rd_req;
  logic [1:0] bank_select = 2'h0, read_latency_cfg = 2'h2;
  logic [1:0] data_pins_oe_n, power_state, wr_lane_en, wr_bank, rd_bank;
  logic [2:0] burst_len_cfg = 3'h2;
  logic [12:0] row_col_addr_bus = 13'h0000, wr_row;
  logic [15:0] data_pins_in = 16'h0000, data_pins_out, wr_data, rd_word;
  logic [3:0] bank_active, precharge_busy;
  logic [9:0] wr_col, rd_col;
  logic [15:0] ew [4];
  int mismatches = 0;
  int num_checks = 0;
  always #25 sys_clk = ~sys_clk;
  sdci_core i_sdci_core (.sys_clk, .rst, .link_clk, .clock_gate, .chip_select_n, .row_strobe_n,
    .column_strobe_n, .write_strobe_n, .bank_select, .row_col_addr_bus, .low_byte_mask,
    .high_byte_mask, .data_pins_in, .data_pins_out, .data_pins_oe_n, .burst_len_cfg,
    .interleave_cfg, .read_latency_cfg, .bank_active, .precharge_busy, .burst_running,
    .power_state, .wr_valid, .wr_ready, .wr_data, .wr_lane_en, .wr_bank, .wr_row, .wr_col,
    .rd_req, .rd_bank, .rd_col, .rd_word);
  sdci_array_model i_sdci_array_model (.sys_clk, .stall, .wr_valid, .wr_ready, .wr_data,
    .wr_lane_en, .wr_bank, .wr_col, .rd_req, .rd_bank, .rd_col, .rd_word);
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // one link period of 8 sys_clk; pins stay put for 6 cycles past the link edge
  task automatic cyc(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
      input logic [15:0] d);
    {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} <= c;
    bank_select <= b;
    row_col_addr_bus <= a;
    data_pins_in <= d;
    repeat (2) @(posedge sys_clk);
    link_clk <= 1'b1;
    repeat (4) @(posedge sys_clk);
    link_clk <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic nop();
    cyc(SDCI_CMD_NOP, bank_select, 13'h0000, 16'h0000);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic read_chk(input logic [12:0] a, input logic [1:0] m, input logic [15:0] e [4]);
    {high_byte_mask, low_byte_mask} <= m;
    cyc(SDCI_CMD_RD, 2'h1, a, 16'h0000);
    {high_byte_mask, low_byte_mask} <= 2'h0;
    repeat (int'(read_latency_cfg) - 1) nop();
    for (int i = 0; i < 4; i++) begin
      nop();
      if (i > 0 || m == 2'h0) check("read word", data_pins_out, e[i]);
      check("read lanes", data_pins_oe_n, (i == 0) ? m : 2'h0);
    end
    nop();
    check("lanes idle", data_pins_oe_n, 2'h3);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [15:0] held;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("reset lanes", data_pins_oe_n, 2'h3);
    check("reset banks", bank_active, SDCI_BANKS_IDLE);
    check("reset state", {wr_valid, power_state}, 3'h0);
    $display("test reset done");
    for (int b = 0; b < 4; b++) cyc(SDCI_CMD_ACT, 2'(b), 13'h0005, 16'h0000);
    nop();
    check("all open", bank_active, 4'hf);
    cyc(SDCI_CMD_PRE, 2'h2, 13'h0000, 16'h0000);
    nop();
    check("bank c closed", bank_active, 4'hb);
    cyc(4'hb, 2'h2, 13'h0005, 16'h0000);
    nop();
    check("deselect", bank_active, 4'hb);
    clock_gate <= 1'b0;
    nop();
    cyc(SDCI_CMD_ACT, 2'h2, 13'h0005, 16'h0000);
    clock_gate <= 1'b1;
    nop();
    nop();
    check("gated activate", bank_active, 4'hb);
    $display("test banks done");
    // array stalls, so the burst must wait in the fifo
    stall <= 1'b1;
    cyc(SDCI_CMD_WR, 2'h1, 13'h0008, 16'h1111);
    {high_byte_mask, low_byte_mask} <= 2'h2;
    cyc(SDCI_CMD_NOP, 2'h1, 13'h0000, 16'h2222);
    {high_byte_mask, low_byte_mask} <= 2'h0;
    cyc(SDCI_CMD_NOP, 2'h1, 13'h0000, 16'h3333);
    cyc(SDCI_CMD_NOP, 2'h1, 13'h0000, 16'h4444);
    check("stalled store", i_sdci_array_model.mem[12'h408], 16'h0000);
    check("queued row", wr_row, 13'h0005);
    check("queued column", wr_col, 10'h008);
    stall <= 1'b0;
    nop();
    ew = '{16'h1111, 16'h0022, 16'h3333, 16'h4444};
    for (int i = 0; i < 4; i++) check("stored word", i_sdci_array_model.mem[12'h408 + i], ew[i]);
    $display("test write done");
    read_chk(13'h0008, 2'h2, ew);
    interleave_cfg <= 1'b1;
    read_latency_cfg <= 2'h3;
    read_chk(13'h0009, 2'h0, '{ew[1], ew[0], ew[3], ew[2]});
    $display("test read done");
    burst_len_cfg <= SDCI_BL_PAGE;
    cyc(SDCI_CMD_RD, 2'h1, 13'h0008, 16'h0000);
    repeat (3) nop();
    clock_gate <= 1'b0;
    repeat (2) nop();
    held = data_pins_out;
    nop();
    check("suspend", power_state, 2'h1);
    check("frozen", data_pins_out, held);
    clock_gate <= 1'b1;
    nop();
    cyc(SDCI_CMD_BST, 2'h1, 13'h0000, 16'h0000);
    repeat (2) nop();
    check("burst stop", burst_running, 1'b0);
    $display("test suspend done");
    cyc(SDCI_CMD_PRE, 2'h0, 13'h0400, 16'h0000);
    nop();
    check("precharge all", bank_active, SDCI_BANKS_IDLE);
    check("precharge timers", precharge_busy, 4'hf);
    // power down needs the precharge timers expired
    repeat (2) nop();
    check("timers expired", precharge_busy, SDCI_BANKS_IDLE);
    clock_gate <= 1'b0;
    repeat (2) nop();
    check("power down", power_state, 2'h3);
    clock_gate <= 1'b1;
    nop();
    check("power down exit", power_state, 2'h0);
    clock_gate <= 1'b0;
    cyc(SDCI_CMD_REF, 2'h0, 13'h0000, 16'h0000);
    nop();
    check("self refresh", power_state, 2'h2);
    clock_gate <= 1'b1;
    nop();
    check("self refresh exit", power_state, 2'h0);
    $display("test power done");
    burst_len_cfg <= SDCI_BL_1;
    cyc(SDCI_CMD_ACT, 2'h3, 13'h0007, 16'h0000);
    cyc(SDCI_CMD_WR, 2'h3, 13'h0402, 16'h5a5a);
    repeat (5) nop();
    check("auto precharge", bank_active, SDCI_BANKS_IDLE);
    check("auto precharge word", i_sdci_array_model.mem[12'hc02], 16'h5a5a);
    $display("test auto precharge done");
    final_report();
  end
endmodule
`default_nettype wire

/* File: dv/sdci_core_sva.sv */
// checker for the sdram command interface ports
`timescale 1ns/1ns
`default_nettype none
module sdci_core_sva
  import sdci_pkg::*;
#(
  parameter int DATA_W = SDCI_DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic clock_gate,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [1:0] bank_select,
  input wire logic [SDCI_ROW_W-1:0] row_col_addr_bus,
  input wire logic [DATA_W-1:0] data_pins_out,
  input wire logic [1:0] data_pins_oe_n,
  input wire logic [SDCI_BANKS-1:0] bank_active,
  input wire logic [SDCI_BANKS-1:0] precharge_busy,
  input wire logic burst_running,
  input wire logic [1:0] power_state,
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire logic [1:0] rd_bank
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] cmd;
  logic link_prev;
  logic [3:0] since_rise;
  assign cmd = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
  // cycles since the raw link edge; synchroniser delay keeps updates early in the period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      link_prev <= 1'b0;
      since_rise <= 4'hf;
    end else begin
      link_prev <= link_clk;
      if (link_clk && !link_prev) since_rise <= 4'h0;
      else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
    end
  end
  sequence s_live;
    $rose(link_clk) && clock_gate && power_state == 2'h0;
  endsequence
  property p_edge_only;
    $changed(bank_active) || $changed(data_pins_out) |-> since_rise <= 4'h5;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("state moved away from a link edge");
  property p_act;
    s_live ##0 cmd == SDCI_CMD_ACT |-> ##[1:5] bank_active[bank_select];
  endproperty
  a_act: assert property (p_act) else $error("activate did not open bank");
  property p_pre_all;
    s_live ##0 cmd == SDCI_CMD_PRE && row_col_addr_bus[SDCI_AP_BIT]
      |-> ##[1:5] bank_active == SDCI_BANKS_IDLE;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");
  property p_desel;
    $rose(link_clk) && chip_select_n && !burst_running
      |-> ##1 $stable(bank_active) [*5];
  endproperty
  a_desel: assert property (p_desel) else $error("deselect changed banks");
  property p_freeze;
    (power_state == 2'h1) [*2] |-> $stable(data_pins_out) && $stable(burst_running);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved in suspend");
  property p_lowpwr;
    power_state[1] |-> data_pins_oe_n == 2'h3 && bank_active == SDCI_BANKS_IDLE
      && precharge_busy == SDCI_BANKS_IDLE;
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("low power with drivers or banks on");
  property p_no_pdn_burst;
    burst_running |-> !power_state[1];
  endproperty
  a_no_pdn_burst: assert property (p_no_pdn_burst) else $error("power down in burst");
  property p_wr;
    s_live ##0 cmd == SDCI_CMD_WR && bank_active[bank_select] |-> ##[1:6] wr_valid;
  endproperty
  a_wr: assert property (p_wr) else $error("write word not queued");
  property p_rd_open;
    rd_req |-> bank_active[rd_bank];
  endproperty
  a_rd_open: assert property (p_rd_open) else $error("read from idle bank");
  c_susp: cover property (power_state == 2'h1);
  c_pdn: cover property (power_state == 2'h3);
  c_sref: cover property (power_state == 2'h2);
  c_wr: cover property (wr_valid);
endmodule
bind sdci_core sdci_core_sva #(.DATA_W(DATA_W)) i_sdci_core_sva (.sys_clk, .rst, .link_clk,
  .clock_gate, .chip_select_n, .row_strobe_n, .column_strobe_n, .write_strobe_n,
  .bank_select, .row_col_addr_bus, .data_pins_out, .data_pins_oe_n, .bank_active,
  .precharge_busy, .burst_running, .power_state, .wr_valid, .rd_req, .rd_bank);
`default_nettype wire

/* File: pkg/sdci_pkg.sv */
// package: constants and types of the sdram command interface
package sdci_pkg;
  localparam int SDCI_ROW_W = 13;
  localparam int SDCI_COL_W = 10;
  localparam int SDCI_BANKS = 4;
  localparam int SDCI_DATA_W = 16;
  localparam int SDCI_AP_BIT = 10;
  localparam int SDCI_MASK_LAT = 2;
  localparam int SDCI_FIFO_DEPTH = 8;
  localparam logic [2:0] SDCI_BL_1 = 3'h0;
  localparam logic [2:0] SDCI_BL_2 = 3'h1;
  localparam logic [2:0] SDCI_BL_4 = 3'h2;
  localparam logic [2:0] SDCI_BL_8 = 3'h3;
  localparam logic [2:0] SDCI_BL_PAGE = 3'h7;
  localparam logic [1:0] SDCI_CL_2 = 2'h2;
  localparam logic [1:0] SDCI_CL_3 = 2'h3;
  localparam logic [3:0] SDCI_BANKS_IDLE = 4'h0;
  localparam logic [9:0] SDCI_COL_ZERO = 10'h000;
  localparam logic [9:0] SDCI_COL_LAST = 10'h3ff;
  localparam logic [4:0] SDCI_PRE_CYC = 5'h03;

  // command code {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDCI_CMD_ACT = 4'h3,
    SDCI_CMD_PRE = 4'h2,
    SDCI_CMD_WR = 4'h4,
    SDCI_CMD_RD = 4'h5,
    SDCI_CMD_MRS = 4'h0,
    SDCI_CMD_NOP = 4'h7,
    SDCI_CMD_BST = 4'h6,
    SDCI_CMD_REF = 4'h1
  } sdci_cmd_t;

  // gray along idle -> active burst -> suspend; low power states off path
  typedef enum logic [2:0] {
    SDCI_ST_RUN = 3'h0,
    SDCI_ST_SUSP = 3'h1,
    SDCI_ST_PDN = 3'h3,
    SDCI_ST_SREF = 3'h2
  } sdci_pwr_t;
endpackage

/* File: verilog/sdci_core.sv */
// file: sdram command interface, device side
// How it works
// (RULE_01) inputs taken only on link clock rising edges
// (RULE_02) each live edge advances burst and outputs
// (RULE_03) low clock_gate freezes burst and outputs
// (RULE_04) idle banks plus low gate: power down/refresh
// (RULE_05) low power mode: gate async, inputs off
// (RULE_06) command valid only if previous gate high
// (RULE_07) bank_select picks bank a to d
// (RULE_08) row on activate, column low ten bits
// (RULE_09) precharge all when auto_precharge_bit high
// (RULE_10) chip_select_n high means deselect
// (RULE_11) row strobe low: activate or precharge
// (RULE_12) column strobe low: read or write
// (RULE_13) masks gate read drivers, block writes
// (RULE_14) burst stop ends running burst only
// (RULE_15) power down during burst becomes suspend
// (RULE_16) controller activates row before access
// (RULE_17) burst lengths 1,2,4,8 or page
// (RULE_18) sequential or interleaved burst order
// (RULE_19) read latency two or three cycles
// (RULE_20) auto precharge after burst ends
// (RULE_21) four banks of sixteen bit words
// (RULE_22) controller waits activate to column delay
// (RULE_23) read mask latency two cycles
// (RULE_24) page burst wraps to column zero
// (RULE_25) controller exits low power with nop
`timescale 1ns/1ns
`default_nettype none
module sdci_core
  import sdci_pkg::*;
#(
  parameter int DATA_W = SDCI_DATA_W,
  parameter int FIFO_DEPTH = SDCI_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic clock_gate,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [1:0] bank_select,
  input wire logic [SDCI_ROW_W-1:0] row_col_addr_bus,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0] data_pins_out,
  output logic [1:0] data_pins_oe_n,
  input wire logic [2:0] burst_len_cfg,
  input wire logic interleave_cfg,
  input wire logic [1:0] read_latency_cfg,
  output logic [SDCI_BANKS-1:0] bank_active,
  output logic [SDCI_BANKS-1:0] precharge_busy,
  output logic burst_running,
  output logic [1:0] power_state,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [DATA_W-1:0] wr_data,
  output logic [1:0] wr_lane_en,
  output logic [1:0] wr_bank,
  output logic [SDCI_ROW_W-1:0] wr_row,
  output logic [SDCI_COL_W-1:0] wr_col,
  output logic rd_req,
  output logic [1:0] rd_bank,
  output logic [SDCI_COL_W-1:0] rd_col,
  input wire logic [DATA_W-1:0] rd_word
);
  // ----------------------------------------
  // pin synchronisers and link edge detect
  // ----------------------------------------
  // gate, command, bank, address, masks and data travel as one word
  localparam int PW = 22 + DATA_W;
  logic [PW-1:0] pin_s1_reg;
  logic [PW-1:0] pin_s2_reg;
  logic [1:0] lclk_reg;
  logic lclk_d_reg;
  logic edge_now;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      lclk_reg <= '0;
      lclk_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {clock_gate, chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n,
                     bank_select, row_col_addr_bus, high_byte_mask, low_byte_mask,
                     data_pins_in};
      pin_s2_reg <= pin_s1_reg;
      // the link clock takes the same two flops as the pins it qualifies
      lclk_reg <= {lclk_reg[0], link_clk};
      lclk_d_reg <= lclk_reg[1];
    end
  end

  // clock is skewed same as data, so edge and data arrive together
  assign edge_now = lclk_reg[1] && !lclk_d_reg; // RULE_01

  logic gate_s;
  sdci_cmd_t cmd_s;
  logic [1:0] bank_s;
  logic [SDCI_ROW_W-1:0] addr_s;
  logic [1:0] mask_s;
  logic [DATA_W-1:0] din_s;
  assign gate_s = pin_s2_reg[PW-1];
  assign cmd_s = sdci_cmd_t'(pin_s2_reg[PW-2:PW-5]);
  assign bank_s = pin_s2_reg[PW-6:PW-7];
  assign addr_s = pin_s2_reg[DATA_W+14:DATA_W+2];
  assign mask_s = pin_s2_reg[DATA_W+1:DATA_W];
  assign din_s = pin_s2_reg[DATA_W-1:0];

  // ----------------------------------------
  // power state and clock gating
  // ----------------------------------------
  sdci_pwr_t pwr_reg;
  logic gate_prev_reg;
  logic clock_gate_prev;
  logic live;
  logic cmd_ok;
  logic all_idle;
  logic burst_reg;

  assign clock_gate_prev = gate_prev_reg;
  // the edge that samples the gate low still runs; the freeze starts one edge later
  assign live = edge_now && clock_gate_prev && (pwr_reg == SDCI_ST_RUN); // RULE_02 RULE_03
  assign cmd_ok = edge_now && clock_gate_prev && (pwr_reg == SDCI_ST_RUN); // RULE_06
  // a running precharge counts as busy, so power down waits for the timers
  assign all_idle = (bank_active == SDCI_BANKS_IDLE) && (precharge_busy == SDCI_BANKS_IDLE);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_reg <= SDCI_ST_RUN;
      gate_prev_reg <= 1'b1;
    end else begin
      if (edge_now) begin
        gate_prev_reg <= gate_s;
      end
      case (pwr_reg)
        SDCI_ST_RUN: begin
          if (cmd_ok && !gate_s) begin
            if (all_idle && !burst_reg && cmd_s == SDCI_CMD_REF) begin
              pwr_reg <= SDCI_ST_SREF; // RULE_04
            end else if (all_idle && !burst_reg) begin
              pwr_reg <= SDCI_ST_PDN; // RULE_04
            end else begin
              pwr_reg <= SDCI_ST_SUSP; // RULE_15 RULE_03
            end
          end
        end
        // commands met in suspend are refused; only the gate is watched
        SDCI_ST_SUSP: begin
          if (edge_now && gate_s) begin
            pwr_reg <= SDCI_ST_RUN;
          end
        end
        // no link edge is needed to leave: gate is watched directly
        SDCI_ST_PDN, SDCI_ST_SREF: begin
          if (gate_s) begin
            pwr_reg <= SDCI_ST_RUN; // RULE_05 RULE_25
          end
        end
        default: pwr_reg <= SDCI_ST_RUN;
      endcase
    end
  end
  assign power_state = pwr_reg[1:0];

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic is_act;
  logic is_pre;
  logic is_rd;
  logic is_wr;
  logic is_bst;
  // chip select is part of the code, so a deselect never matches a command
  assign is_act = cmd_ok && (cmd_s == SDCI_CMD_ACT); // RULE_10 RULE_11
  assign is_pre = cmd_ok && (cmd_s == SDCI_CMD_PRE); // RULE_11
  // a column command to an idle bank is dropped, not queued
  assign is_rd = cmd_ok && (cmd_s == SDCI_CMD_RD) && bank_active[bank_s]; // RULE_12 RULE_16
  assign is_wr = cmd_ok && (cmd_s == SDCI_CMD_WR) && bank_active[bank_s]; // RULE_12 RULE_16

  // ----------------------------------------
  // banks: open rows and auto precharge
  // ----------------------------------------
  logic [SDCI_ROW_W-1:0] row_reg [SDCI_BANKS];
  logic [SDCI_BANKS-1:0] act_reg;
  logic [4:0] pre_cnt_reg [SDCI_BANKS];
  logic ap_reg;
  logic [1:0] bank_reg;
  logic burst_end;
  logic ap_single;

  // a one word write runs no burst, so its auto precharge starts at once
  assign ap_single = is_wr && (burst_len_cfg == SDCI_BL_1) && addr_s[SDCI_AP_BIT]; // RULE_20

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_reg <= '0;
      for (int i = 0; i < SDCI_BANKS; i++) begin
        row_reg[i] <= '0;
        pre_cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < SDCI_BANKS; i++) begin
        // timers count link edges only, so a stopped link stretches precharge
        if (edge_now && pre_cnt_reg[i] != '0) begin
          pre_cnt_reg[i] <= pre_cnt_reg[i] - 5'h01;
        end
        if (is_act && bank_s == 2'(i)) begin
          act_reg[i] <= 1'b1; // RULE_07 RULE_21
          row_reg[i] <= addr_s; // RULE_08
        end
        if (is_pre && (addr_s[SDCI_AP_BIT] || bank_s == 2'(i))) begin
          act_reg[i] <= 1'b0; // RULE_09
          pre_cnt_reg[i] <= SDCI_PRE_CYC;
        end
        if ((burst_end && ap_reg && bank_reg == 2'(i)) || (ap_single && bank_s == 2'(i))) begin
          act_reg[i] <= 1'b0; // RULE_20
          pre_cnt_reg[i] <= SDCI_PRE_CYC;
        end
      end
    end
  end
  assign bank_active = act_reg;
  always_comb begin
    for (int i = 0; i < SDCI_BANKS; i++) begin
      precharge_busy[i] = (pre_cnt_reg[i] != '0);
    end
  end

  // ----------------------------------------
  // burst counter
  // ----------------------------------------
  logic [SDCI_COL_W-1:0] start_reg;
  logic [SDCI_COL_W-1:0] idx_reg;
  logic [SDCI_COL_W-1:0] col_now;
  logic [SDCI_COL_W-1:0] len_m1;
  logic is_read_reg;
  logic page_mode;

  assign page_mode = (burst_len_cfg == SDCI_BL_PAGE);
  always_comb begin
    case (burst_len_cfg)
      SDCI_BL_1: len_m1 = 10'h000; // RULE_17
      SDCI_BL_2: len_m1 = 10'h001;
      SDCI_BL_4: len_m1 = 10'h003;
      SDCI_BL_8: len_m1 = 10'h007;
      default: len_m1 = SDCI_COL_LAST;
    endcase
  end
  // page bursts wrap naturally through the ten bit adder
  always_comb begin
    if (interleave_cfg && !page_mode) begin
      col_now = (start_reg & ~len_m1) | ((start_reg ^ idx_reg) & len_m1); // RULE_18
    end else begin
      col_now = (start_reg & ~len_m1) | ((start_reg + idx_reg) & len_m1); // RULE_18 RULE_24
    end
  end
  assign is_bst = cmd_ok && (cmd_s == SDCI_CMD_BST) && burst_reg; // RULE_14
  // a read burst ends on the edge that fetches its last word
  assign burst_end = burst_reg && live && !page_mode && (idx_reg == len_m1) && !is_rd && !is_wr;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      burst_reg <= 1'b0;
      is_read_reg <= 1'b0;
      start_reg <= '0;
      idx_reg <= '0;
      ap_reg <= 1'b0;
      bank_reg <= '0;
    end else if (is_rd || is_wr) begin
      burst_reg <= 1'b1;
      is_read_reg <= is_rd;
      start_reg <= addr_s[SDCI_COL_W-1:0]; // RULE_08
      // a write takes word zero on the command edge, so its count starts at one
      idx_reg <= is_wr ? 10'h001 : SDCI_COL_ZERO;
      ap_reg <= addr_s[SDCI_AP_BIT] && !page_mode; // RULE_08 RULE_20
      bank_reg <= bank_s;
      if (is_wr && burst_len_cfg == SDCI_BL_1) begin
        burst_reg <= 1'b0;
      end
    end else if (is_bst || burst_end) begin
      burst_reg <= 1'b0; // RULE_14
      ap_reg <= 1'b0;
    end else if (burst_reg && live) begin
      idx_reg <= idx_reg + 10'h001; // RULE_02
    end
  end
  assign burst_running = burst_reg;

  // ----------------------------------------
  // write path through fifo
  // ----------------------------------------
  logic wr_take;
  logic [SDCI_COL_W-1:0] wcol;
  assign wr_take = is_wr || (burst_reg && !is_read_reg && live && !is_bst && !is_rd);
  assign wcol = is_wr ? addr_s[SDCI_COL_W-1:0] : col_now;

  logic [DATA_W+SDCI_ROW_W+SDCI_COL_W+3:0] fin;
  logic [DATA_W+SDCI_ROW_W+SDCI_COL_W+3:0] fout;
  logic [1:0] wb;
  assign wb = is_wr ? bank_s : bank_reg;
  // lane enables are the inverted masks: a high mask keeps that byte
  assign fin = {din_s, ~mask_s, wb, row_reg[wb], wcol}; // RULE_13
  // a full fifo drops words: the array side must keep up with the link
  sdci_fifo #(.WIDTH(DATA_W + SDCI_ROW_W + SDCI_COL_W + 4), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(wr_take),
    .in_ready(),
    .in_data(fin),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fout)
  );
  assign {wr_data, wr_lane_en, wr_bank, wr_row, wr_col} = fout;

  // ----------------------------------------
  // read path: latency pipe and mask pipe
  // ----------------------------------------
  logic [2:0] rdv_reg;
  logic [DATA_W-1:0] rdd_reg [3];
  logic [1:0] mpipe_reg [SDCI_MASK_LAT];
  logic [DATA_W-1:0] dout_reg;
  logic [1:0] oe_n_reg;
  logic rd_fire;
  logic tap_v;
  logic [DATA_W-1:0] tap_d;

  // the counter fetches every word of the burst, the last one included
  assign rd_fire = is_rd || (burst_reg && is_read_reg && live && !is_wr && !is_bst);
  assign rd_req = rd_fire;
  assign rd_bank = is_rd ? bank_s : bank_reg;
  assign rd_col = is_rd ? addr_s[SDCI_COL_W-1:0] : col_now;
  // every word issued by the counter; the command's own fetch enters the pipe marked invalid
  assign tap_v = (read_latency_cfg == SDCI_CL_3) ? rdv_reg[1] : rdv_reg[0]; // RULE_19
  assign tap_d = (read_latency_cfg == SDCI_CL_3) ? rdd_reg[1] : rdd_reg[0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdv_reg <= '0;
      dout_reg <= '0;
      oe_n_reg <= 2'h3;
      for (int i = 0; i < 3; i++) begin
        rdd_reg[i] <= '0;
      end
      for (int i = 0; i < SDCI_MASK_LAT; i++) begin
        mpipe_reg[i] <= 2'h3;
      end
    end else if (live) begin
      rdv_reg <= {rdv_reg[1:0], rd_fire && !is_rd};
      rdd_reg[0] <= rd_word;
      rdd_reg[1] <= rdd_reg[0];
      rdd_reg[2] <= rdd_reg[1];
      // masks ride the data pipe, so a suspend cannot skew them apart
      mpipe_reg[0] <= mask_s;
      mpipe_reg[1] <= mpipe_reg[0]; // RULE_23
      dout_reg <= tap_d; // RULE_02
      // lanes float outside read data, leaving the pins to the controller
      oe_n_reg <= tap_v ? mpipe_reg[1] : 2'h3; // RULE_13 RULE_23
    end else if (edge_now && is_rd) begin
      rdv_reg <= {rdv_reg[1:0], 1'b1};
      rdd_reg[0] <= rd_word;
    end
  end
  assign data_pins_out = dout_reg;
  assign data_pins_oe_n = oe_n_reg;
endmodule
`default_nettype wire

/* File: verilog/sdci_fifo.sv */
// file: fifo carrying write words into the array
`timescale 1ns/1ns
`default_nettype none
module sdci_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rp_reg];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire
